// ### design/adcsc_seq_ctrl.sv
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
module adcsc_seq_ctrl
   import adcsc_pkg::*;
#(
   parameter int RAW_W = 10
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic conv_start,
   output logic [3:0] conv_chan,
   output logic conv_port_en,
   output logic [2:0] conv_port_sel,
   output adcsc_ref_type conv_ref_sel,
   input wire logic conv_done,
   input wire logic signed [RAW_W-1:0] conv_data
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // register index: 0 control, 1..4 result slots, 5 status, 7 none
   function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [2:0] r;
      r = 3'h7;
      if (a[ADDR_W-1:2] == OFF_CONTROL[ADDR_W-1:2]) begin
         r = 3'h0;
      end else if (a[ADDR_W-1:2] >= OFF_RESULT_FIRST[ADDR_W-1:2] &&
                   a[ADDR_W-1:2] <= OFF_RESULT_FOURTH[ADDR_W-1:2]) begin
         r = 3'(a[ADDR_W-1:2] - OFF_RESULT_FIRST[ADDR_W-1:2]) + 3'h1;
      end else if (a[ADDR_W-1:2] == OFF_STATUS[ADDR_W-1:2]) begin
         r = 3'h5;
      end
      return r;
   endfunction : reg_index

   // channel to be converted for a given control word and slot
   function automatic logic [3:0] pick_chan(input logic [CTRL_W-1:0] c,
                                            input logic [1:0] s);
      logic [3:0] r;
      r = c[CTRL_CHAN_LSB +: 4];
      if (c[CTRL_MULTI_BIT]) begin
         r = {c[CTRL_CHAN_LSB+2 +: 2], s};
      end
      return r;
   endfunction : pick_chan

   // routing of a channel code onto port pins or reference points
   function automatic logic [5:0] route(input logic [3:0] ch);
      logic [5:0] r;
      r = {1'b0, 3'h0, REF_NONE};
      if (ch <= CH_PORT_LAST) begin
         r = {1'b1, ch[2:0], REF_NONE};
      end else if (ch == CH_HIGH_REF) begin
         r = {1'b0, 3'h0, REF_HIGH};
      end else if (ch == CH_LOW_REF) begin
         r = {1'b0, 3'h0, REF_LOW};
      end else if (ch == CH_HALF_REF) begin
         r = {1'b0, 3'h0, REF_HALF};
      end
      return r;
   endfunction : route

   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic ctrl_load;
   logic [CTRL_W-1:0] ctrl_reg;
   adcsc_seq_type seq_state;
   logic [1:0] slot_idx;
   logic seq_done;
   logic store;
   logic last_slot;
   logic [1:0] next_slot;
   logic [5:0] next_route;
   logic [5:0] first_route;
   logic [SLOTS-1:0][7:0] slot_q;

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   // address and data are taken in either order; the write acts once
   // both are held and no response is still outstanding
   assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign ctrl_load = do_write && (reg_index(aw_addr) == 3'h0) &&
                      w_strb[0];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_wready <= 1'b1;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // response: read-only registers ignore writes but answer okay
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (reg_index(aw_addr) == 3'h7) ? AXI_DECERR
                                                      : AXI_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control word; only byte lane 0 carries bits
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (ctrl_load) begin
         ctrl_reg <= w_data[CTRL_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= AXI_OKAY;
         s_axi_rdata <= '0;
         unique case (reg_index(s_axi_araddr))
            3'h0: s_axi_rdata <= {26'h0, ctrl_reg};
            3'h1, 3'h2, 3'h3, 3'h4: begin
               s_axi_rdata <=
                  {24'h0, slot_q[2'(reg_index(s_axi_araddr) - 3'h1)]};
            end
            3'h5: begin
               s_axi_rdata[STAT_BUSY_BIT] <= (seq_state != SEQ_IDLE);
               s_axi_rdata[STAT_DONE_BIT] <= seq_done;
               s_axi_rdata[STAT_SLOT_LSB +: 2] <= slot_idx;
            end
            default: s_axi_rresp <= AXI_DECERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // conversion sequencer
   // ---------------------------------------------------------------
   // a result is kept only while running and not being aborted; a done
   // that meets a start pulse belongs to the conversion just abandoned
   assign store = (seq_state == SEQ_RUN) && conv_done && !ctrl_load &&
                  !conv_start;
   assign last_slot = (slot_idx == 2'(SLOTS - 1));
   assign next_slot = slot_idx + 2'h1; // wraps to the first slot
   assign next_route = route(pick_chan(ctrl_reg, next_slot));
   assign first_route = route(pick_chan(ctrl_reg, 2'h0));

   // the arm state is the one-cycle gap between write and start
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         seq_state <= SEQ_IDLE;
         slot_idx <= 2'h0;
         seq_done <= 1'b0;
      end else if (ctrl_load) begin
         seq_state <= SEQ_ARM;
         slot_idx <= 2'h0;
         seq_done <= 1'b0;
      end else begin
         unique case (seq_state)
            SEQ_IDLE: seq_state <= SEQ_IDLE;
            SEQ_ARM: seq_state <= SEQ_RUN;
            SEQ_RUN: begin
               if (store) begin
                  slot_idx <= next_slot;
                  if (last_slot && !ctrl_reg[CTRL_SCAN_BIT]) begin
                     seq_state <= SEQ_IDLE;
                     seq_done <= 1'b1;
                  end
               end
            end
            default: seq_state <= SEQ_IDLE;
         endcase
      end
   end

   // start pulse and channel routing, updated together so the core
   // sees a stable select on the cycle it is told to begin
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         conv_start <= 1'b0;
         conv_chan <= 4'h0;
         conv_port_en <= 1'b0;
         conv_port_sel <= 3'h0;
         conv_ref_sel <= REF_NONE;
      end else begin
         conv_start <= 1'b0;
         if (!ctrl_load && seq_state == SEQ_ARM) begin
            conv_start <= 1'b1;
            conv_chan <= pick_chan(ctrl_reg, 2'h0);
            {conv_port_en, conv_port_sel} <= first_route[5:2];
            conv_ref_sel <= adcsc_ref_type'(first_route[1:0]);
         end else if (store &&
                      !(last_slot && !ctrl_reg[CTRL_SCAN_BIT])) begin
            conv_start <= 1'b1;
            conv_chan <= pick_chan(ctrl_reg, next_slot);
            {conv_port_en, conv_port_sel} <= next_route[5:2];
            conv_ref_sel <= adcsc_ref_type'(next_route[1:0]);
         end
      end
   end

   adcsc_result_bank #(
      .RAW_W(RAW_W)
   ) u_bank (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(store),
      .wr_slot(slot_idx),
      .raw(conv_data),
      .slot_q(slot_q)
   );

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_arm_gap;
      (seq_state == SEQ_ARM) && !conv_start;
   endsequence

   sequence s_final_store;
      store && last_slot && !ctrl_reg[CTRL_SCAN_BIT];
   endsequence

   a_start_one_cycle: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl_load |=> s_arm_gap ##1 conv_start)
      else $error("start did not follow control write by one cycle");

   a_chan_from_ctrl: assert property (@(posedge mclk) disable iff (!rstn)
      (s_arm_gap and !ctrl_load)
      |=> conv_chan == pick_chan($past(ctrl_reg), 2'h0))
      else $error("first channel does not match control bits");

   a_chan_select: assert property (@(posedge mclk) disable iff (!rstn)
      conv_start |-> conv_chan == pick_chan(ctrl_reg, slot_idx))
      else $error("channel select differs from mode and slot");

   a_port_route: assert property (@(posedge mclk) disable iff (!rstn)
      conv_start && conv_chan <= CH_PORT_LAST
      |-> conv_port_en && conv_port_sel == conv_chan[2:0] &&
          conv_ref_sel == REF_NONE)
      else $error("port channel routed to wrong input");

   a_ref_route: assert property (@(posedge mclk) disable iff (!rstn)
      conv_start && conv_chan > CH_PORT_LAST
      |-> !conv_port_en &&
          conv_ref_sel == ((conv_chan == CH_HIGH_REF) ? REF_HIGH :
                           (conv_chan == CH_LOW_REF) ? REF_LOW :
                           (conv_chan == CH_HALF_REF) ? REF_HALF :
                           REF_NONE))
      else $error("reference or reserved channel misrouted");

   a_group_slot: assert property (@(posedge mclk) disable iff (!rstn)
      conv_start && ctrl_reg[CTRL_MULTI_BIT]
      |-> conv_chan[1:0] == slot_idx &&
          conv_chan[3:2] == ctrl_reg[CTRL_CHAN_LSB+2 +: 2])
      else $error("multi mode slot does not follow group position");

   a_halt_after_four: assert property (@(posedge mclk) disable iff (!rstn)
      s_final_store ##1 !ctrl_load [*2]
      |-> seq_state == SEQ_IDLE && seq_done && !conv_start)
      else $error("sequence did not halt after fourth result");

   a_scan_wrap: assert property (@(posedge mclk) disable iff (!rstn)
      store && last_slot && ctrl_reg[CTRL_SCAN_BIT]
      |=> slot_idx == 2'h0 && conv_start && seq_state == SEQ_RUN)
      else $error("scan mode did not wrap to the first slot");

   a_abort_restart: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl_load |=> slot_idx == 2'h0 && !seq_done &&
                    ctrl_reg == $past(w_data[CTRL_W-1:0]))
      else $error("control write did not restart the sequence");

   a_bvalid_holds: assert property (@(posedge mclk) disable iff (!rstn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before it was taken");

endmodule : adcsc_seq_ctrl

// ### design/adcsc_pkg.sv
package adcsc_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_RESULT_FIRST = 8'h04;
   localparam logic [7:0] OFF_RESULT_FOURTH = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;

   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_W = 6;
   localparam int CTRL_CHAN_LSB = 0;
   localparam int CTRL_MULTI_BIT = 4;
   localparam int CTRL_SCAN_BIT = 5;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_SLOT_LSB = 2;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam int SLOTS = 4;

   // ---------------------------------------------------------------
   // codes, channel numbers (channel code = channel number)
   // ---------------------------------------------------------------
   localparam logic [7:0] CODE_LOW = 8'h00;
   localparam logic [7:0] CODE_HIGH = 8'hff;
   localparam logic [3:0] CH_PORT_LAST = 4'h7;
   localparam logic [3:0] CH_HIGH_REF = 4'hc;
   localparam logic [3:0] CH_LOW_REF = 4'hd;
   localparam logic [3:0] CH_HALF_REF = 4'he;
   localparam int START_DELAY_CYC = 1;

   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_DECERR = 2'h3;

   typedef enum logic [1:0] {
      REF_NONE = 2'h0,
      REF_HIGH = 2'h1,
      REF_LOW = 2'h2,
      REF_HALF = 2'h3
   } adcsc_ref_type;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'h0,
      SEQ_ARM = 2'h1,
      SEQ_RUN = 2'h3
   } adcsc_seq_type;

endpackage : adcsc_pkg

// ### design/adcsc_result_bank.sv
module adcsc_result_bank
   import adcsc_pkg::*;
#(
   parameter int RAW_W = 10
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [1:0] wr_slot,
   input wire logic signed [RAW_W-1:0] raw,
   output logic [SLOTS-1:0][7:0] slot_q
);

   // ---------------------------------------------------------------
   // saturation
   // ---------------------------------------------------------------
   // out-of-range inputs pin to the rails; nothing records that it
   // happened, so software cannot tell a clipped value from a true one
   function automatic logic [7:0] clamp(input logic signed [RAW_W-1:0] v);
      logic [7:0] r;
      r = v[7:0];
      if (v[RAW_W-1]) begin
         r = CODE_LOW;
      end else if (|v[RAW_W-2:8]) begin
         r = CODE_HIGH;
      end
      return r;
   endfunction : clamp

   // ---------------------------------------------------------------
   // slot storage
   // ---------------------------------------------------------------
   for (genvar i = 0; i < SLOTS; i++) begin : g_slot
      // one flop byte per slot, loaded when its index is addressed
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            slot_q[i] <= RESULT_RESET;
         end else if (wr_en && (wr_slot == 2'(i))) begin
            slot_q[i] <= clamp(raw);
         end
      end
   end

   a_clamp_low: assert property (@(posedge mclk) disable iff (!rstn)
      wr_en && raw[RAW_W-1] |=> slot_q[$past(wr_slot)] == CODE_LOW)
      else $error("negative input did not give the low code");

   a_clamp_high: assert property (@(posedge mclk) disable iff (!rstn)
      wr_en && !raw[RAW_W-1] && (|raw[RAW_W-2:8])
      |=> slot_q[$past(wr_slot)] == CODE_HIGH)
      else $error("over-range input did not give the high code");

endmodule : adcsc_result_bank

// ### sim/adcsc_core_model.sv
// far-side stand-in: analog mux plus converter core
module adcsc_core_model
   import adcsc_pkg::*;
#(
   parameter int RAW_W = 10
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic conv_start,
   input wire logic conv_port_en,
   input wire logic [2:0] conv_port_sel,
   input adcsc_ref_type conv_ref_sel,
   input wire logic [7:0] wait_cyc,
   output logic conv_done,
   output logic signed [RAW_W-1:0] conv_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic busy;
   logic [7:0] cnt;
   logic signed [RAW_W-1:0] held;

   // -------------------------------------------------------------
   // raw level per input; high and low refs reach past full scale on purpose, half ref stays inside
   // -------------------------------------------------------------
   function automatic logic signed [RAW_W-1:0] level();
      if (conv_port_en) return RAW_W'(conv_port_sel * 20 + 3);
      case (conv_ref_sel)
         REF_HIGH: return RAW_W'(400);
         REF_LOW: return RAW_W'(-7);
         REF_HALF: return RAW_W'(128);
         default: return RAW_W'(85);
      endcase
   endfunction : level

   // a new start abandons work in flight; data toggles when not valid
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         conv_done <= 1'b0;
         conv_data <= '0;
         held <= '0;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
         if (conv_start) begin
            busy <= 1'b1;
            cnt <= wait_cyc;
            held <= level();
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= held;
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : adcsc_core_model

// ### sim/adc_sequence_channel_control_tb.sv
module adc_sequence_channel_control_tb
   import adcsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk, rstn;
   logic [7:0] s_axi_awaddr, s_axi_araddr, wait_cyc;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, conv_chan;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic conv_start, conv_port_en, conv_done;
   logic [2:0] conv_port_sel;
   adcsc_ref_type conv_ref_sel;
   logic signed [9:0] conv_data;
   int error_cnt = 0;
   int check_count = 0;
   int start_cnt = 0;
   int n0, n;

   adcsc_seq_ctrl #(.RAW_W(10)) i_dut (.mclk(mclk), .rstn(rstn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .conv_start(conv_start),
      .conv_chan(conv_chan), .conv_port_en(conv_port_en),
      .conv_port_sel(conv_port_sel), .conv_ref_sel(conv_ref_sel),
      .conv_done(conv_done), .conv_data(conv_data));

   adcsc_core_model #(.RAW_W(10)) i_core (.mclk(mclk), .rstn(rstn),
      .conv_start(conv_start), .conv_port_en(conv_port_en),
      .conv_port_sel(conv_port_sel), .conv_ref_sel(conv_ref_sel),
      .wait_cyc(wait_cyc), .conv_done(conv_done), .conv_data(conv_data));

   // -------------------------------------------------------------
   // clock and start-pulse counter
   // -------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (conv_start === 1'b1) start_cnt++;
   end

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic timeout();
      error_cnt++;
      $display("ERROR at %0t: wait ran out", $time);
      conclude();
   endtask : timeout

   // both ready lines stay high, so an answer is taken when seen
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                            input logic [3:0] st, input logic [1:0] er);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (k == 50) timeout();
      check(32'(s_axi_bresp), 32'(er));
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                           input logic [1:0] er);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (k == 50) timeout();
      v = s_axi_rdata;
      check(32'(s_axi_rresp), 32'(er));
   endtask : axi_read

   task automatic wait_done();
      logic [31:0] s;
      int k;
      for (k = 0; k < 200; k++) begin
         axi_read(OFF_STATUS, s, AXI_OKAY);
         if (s[STAT_DONE_BIT] === 1'b1) break;
      end
      if (k == 200) timeout();
   endtask : wait_done

   task automatic slots_are(input logic [3:0] c0, input logic multi);
      logic [31:0] v;
      for (int i = 0; i < SLOTS; i++) begin
         axi_read(OFF_RESULT_FIRST + 8'(4 * i), v, AXI_OKAY);
         check(v, 32'(exp_code(multi ? {c0[3:2], 2'(i)} : c0)));
      end
   endtask : slots_are

   function automatic logic [31:0] ctl(input logic s, input logic m,
                                       input logic [3:0] c);
      return {26'h0, s, m, c};
   endfunction : ctl

   // expected code from the channel code and the core's levels
   function automatic logic [7:0] exp_code(input logic [3:0] c);
      if (c <= CH_PORT_LAST) return 8'(c * 20 + 3);
      if (c == CH_HIGH_REF) return CODE_HIGH;
      if (c == CH_LOW_REF) return CODE_LOW;
      if (c == CH_HALF_REF) return 8'h80;
      return 8'h55;
   endfunction : exp_code

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      wait_cyc = 8'h00;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      axi_read(OFF_CONTROL, d, AXI_OKAY);
      check(d, 32'(CTRL_RESET));
      axi_read(OFF_RESULT_FOURTH, d, AXI_OKAY);
      check(d, 32'(RESULT_RESET));
      // start lands exactly one cycle after the write takes effect
      axi_write(OFF_CONTROL, ctl(1'b0, 1'b0, 4'h6), 4'hf, AXI_OKAY);
      check(32'(conv_start), 32'h0);
      @(posedge mclk);
      check(32'(conv_start), 32'h1);
      check(32'(conv_chan), 32'h6);
      wait_done();
      // every channel code, single mode, core speed varied
      for (int c = 0; c < 16; c++) begin
         wait_cyc <= 8'(c % 3);
         axi_write(OFF_CONTROL, ctl(1'b0, 1'b0, 4'(c)), 4'hf, AXI_OKAY);
         wait_done();
         slots_are(4'(c), 1'b0);
      end
      // after four results the sequence stays idle
      n0 = start_cnt;
      repeat (30) @(posedge mclk);
      check(32'(start_cnt - n0), 32'h0);
      axi_read(OFF_STATUS, d, AXI_OKAY);
      check(32'(d[STAT_BUSY_BIT]), 32'h0);
      // multi mode: slot follows position inside the group
      for (int g = 0; g < 4; g++) begin
         axi_write(OFF_CONTROL, ctl(1'b0, 1'b1, 4'(4 * g + 1)), 4'hf,
                   AXI_OKAY);
         wait_done();
         slots_are(4'(4 * g), 1'b1);
      end
      // scan keeps converting well past four results
      wait_cyc <= 8'h01;
      axi_write(OFF_CONTROL, ctl(1'b1, 1'b0, 4'h3), 4'hf, AXI_OKAY);
      n0 = start_cnt;
      repeat (80) @(posedge mclk);
      check({31'h0, (start_cnt - n0) >= 10}, 32'h1);
      axi_read(OFF_STATUS, d, AXI_OKAY);
      check(32'(d[STAT_DONE_BIT]), 32'h0);
      slots_are(4'h3, 1'b0);
      // back-to-back writes: abort, first result lands in slot one
      wait_cyc <= 8'd20;
      axi_write(OFF_CONTROL, ctl(1'b0, 1'b0, CH_HIGH_REF), 4'hf, AXI_OKAY);
      axi_write(OFF_CONTROL, ctl(1'b0, 1'b0, CH_LOW_REF), 4'hf, AXI_OKAY);
      for (n = 0; n < 100 && conv_done !== 1'b1; n++) @(posedge mclk);
      if (n == 100) timeout();
      @(posedge mclk);
      axi_read(OFF_RESULT_FIRST, d, AXI_OKAY);
      check(d, 32'(CODE_LOW));
      axi_read(OFF_RESULT_FIRST + 8'h04, d, AXI_OKAY);
      check(d, 32'(exp_code(4'h3)));
      wait_done();
      slots_are(CH_LOW_REF, 1'b0);
      // refused and ignored accesses
      axi_read(8'h18, d, AXI_DECERR);
      check(d, 32'h0);
      axi_write(8'h18, 32'h0, 4'hf, AXI_DECERR);
      axi_write(OFF_RESULT_FIRST, 32'h5a, 4'hf, AXI_OKAY);
      n0 = start_cnt;
      axi_write(OFF_CONTROL, ctl(1'b0, 1'b0, 4'h1), 4'he, AXI_OKAY);
      repeat (5) @(posedge mclk);
      check(32'(start_cnt - n0), 32'h0);
      axi_read(OFF_CONTROL, d, AXI_OKAY);
      check(d, ctl(1'b0, 1'b0, CH_LOW_REF));
      slots_are(CH_LOW_REF, 1'b0);
      conclude();
   end
endmodule : adc_sequence_channel_control_tb
